//--- rtl/sfoc_core.sv
`timescale 1ns/1ns
`default_nettype none
module sfoc_core import sfoc_pkg::*; #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic sample_valid,
    output logic sample_ready,
    input wire sfoc_sample_s sample_data,
    output sfoc_mod_s mod_data,
    output logic mod_valid,
    output logic mod_polar,
    output logic motor_run,
    output logic [15:0] speed_target,
    output logic [15:0] rotor_angle
);
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
        if (v > 32'sd32767) begin
            return 16'sh7FFF;
        end else if (v < -32'sd32768) begin
            return 16'sh8000;
        end
        return v[15:0];
    endfunction : sat16

    function automatic logic signed [15:0] mulq(input logic signed [15:0] a, input logic signed [15:0] b);
        logic signed [31:0] p;
        p = a * b;
        return sat16(p >>> 15);
    endfunction : mulq

    function automatic logic signed [15:0] addq(input logic signed [15:0] a, input logic signed [15:0] b);
        return sat16(32'(a) + 32'(b));
    endfunction : addq

    function automatic logic [15:0] lane16(input logic [15:0] old, input logic [3:0] be, input logic [31:0] wd);
        return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : lane16

    function automatic logic signed [19:0] atan_step(input logic [3:0] i);
        logic signed [19:0] r;
        r = '0;
        unique case (i)
            4'd0: r = 20'sd8192;
            4'd1: r = 20'sd4836;
            4'd2: r = 20'sd2555;
            4'd3: r = 20'sd1297;
            4'd4: r = 20'sd651;
            4'd5: r = 20'sd326;
            4'd6: r = 20'sd163;
            4'd7: r = 20'sd81;
            4'd8: r = 20'sd41;
            4'd9: r = 20'sd20;
            4'd10: r = 20'sd10;
            4'd11: r = 20'sd5;
            4'd12: r = 20'sd3;
            default: r = 20'sd1;
        endcase
        return r;
    endfunction : atan_step

    // ****************************************
    // sample fifo
    // ****************************************
    logic fifo_valid, fifo_pop;
    sfoc_sample_s fifo_data;
    sfoc_fifo #(.WIDTH($bits(sfoc_sample_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(sys_clk),
        .resetn(resetn),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .in_data(sample_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // ****************************************
    // register bus
    // ****************************************
    logic [15:0] ctrl_q, res_q, ind_q, dt_q, vd_q, vq_q, thr_q, smin_q, smax_q, vf_q, pp_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic signed [15:0] id_q, iq_q;
    logic busy;
    logic bus_req, bus_go;
    sfoc_mode_e mode;

    assign bus_req = avs_read || avs_write;
    assign bus_go = bus_req && wait_q;
    assign avs_waitrequest = wait_q;
    assign avs_readdata = rdata_q;
    assign mode = sfoc_mode_e'(ctrl_q[SFOC_CTRL_MODE_LSB +: 2]);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wait_q <= 1'b1;
            rdata_q <= '0;
        end else begin
            wait_q <= !bus_go;
            if (bus_go && avs_read) begin
                unique case (avs_address)
                    SFOC_CTRL_OFS: rdata_q <= {16'h0000, ctrl_q};
                    SFOC_RES_OFS: rdata_q <= {16'h0000, res_q};
                    SFOC_IND_OFS: rdata_q <= {16'h0000, ind_q};
                    SFOC_DT_OFS: rdata_q <= {16'h0000, dt_q};
                    SFOC_VD_OFS: rdata_q <= {16'h0000, vd_q};
                    SFOC_VQ_OFS: rdata_q <= {16'h0000, vq_q};
                    SFOC_THR_OFS: rdata_q <= {16'h0000, thr_q};
                    SFOC_SMIN_OFS: rdata_q <= {16'h0000, smin_q};
                    SFOC_SMAX_OFS: rdata_q <= {16'h0000, smax_q};
                    SFOC_VF_OFS: rdata_q <= {16'h0000, vf_q};
                    SFOC_PP_OFS: rdata_q <= {16'h0000, pp_q};
                    SFOC_STAT_OFS: rdata_q <= {14'h0000, busy, motor_run, speed_target};
                    SFOC_IDQ_OFS: rdata_q <= {iq_q, id_q};
                    SFOC_ANG_OFS: rdata_q <= {16'h0000, rotor_angle};
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // configuration written by software, R and L never measured here (see [RQ9]) (see [RQ12])
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= SFOC_CTRL_RST;
            res_q <= SFOC_PARAM_RST;
            ind_q <= SFOC_PARAM_RST;
            dt_q <= SFOC_DT_RST;
            vd_q <= SFOC_PARAM_RST;
            vq_q <= SFOC_PARAM_RST;
            thr_q <= SFOC_PARAM_RST;
            smin_q <= SFOC_PARAM_RST;
            smax_q <= SFOC_PARAM_RST;
            vf_q <= SFOC_PARAM_RST;
            pp_q <= SFOC_PP_RST;
        end else if (bus_go && avs_write) begin
            unique case (avs_address)
                SFOC_CTRL_OFS: ctrl_q <= lane16(ctrl_q, avs_byteenable, avs_writedata);
                SFOC_RES_OFS: res_q <= lane16(res_q, avs_byteenable, avs_writedata);
                SFOC_IND_OFS: ind_q <= lane16(ind_q, avs_byteenable, avs_writedata);
                SFOC_DT_OFS: dt_q <= lane16(dt_q, avs_byteenable, avs_writedata);
                SFOC_VD_OFS: vd_q <= lane16(vd_q, avs_byteenable, avs_writedata);
                SFOC_VQ_OFS: vq_q <= lane16(vq_q, avs_byteenable, avs_writedata);
                SFOC_THR_OFS: thr_q <= lane16(thr_q, avs_byteenable, avs_writedata);
                SFOC_SMIN_OFS: smin_q <= lane16(smin_q, avs_byteenable, avs_writedata);
                SFOC_SMAX_OFS: smax_q <= lane16(smax_q, avs_byteenable, avs_writedata);
                SFOC_VF_OFS: vf_q <= lane16(vf_q, avs_byteenable, avs_writedata);
                SFOC_PP_OFS: pp_q <= lane16(pp_q, avs_byteenable, avs_writedata);
                default: ;
            endcase
        end
    end

    // ****************************************
    // update sequencer
    // ****************************************
    typedef enum logic [2:0] {ST_IDLE, ST_CLARKE, ST_FLUX, ST_VEC, ST_ROT, ST_PARK, ST_POL, ST_OUT} sfoc_st_e;
    sfoc_st_e st_q;
    sfoc_sample_s smp_q;
    logic signed [15:0] ia_q, ib_q, psa_q, psb_q, ppa_q, ppb_q, cos_q, sin_q, va_q, vb_q, vdu_q, vqu_q;
    logic signed [19:0] cx_q, cy_q, cz_q;
    logic [3:0] it_q;
    logic [15:0] ramp_q, est_q, pmag_q, pang_q;
    logic cord_last, cord_dir;
    logic [15:0] pot_adc;
    logic [31:0] spd_span;

    assign busy = st_q != ST_IDLE;
    assign fifo_pop = fifo_valid && st_q == ST_IDLE;
    assign cord_last = it_q == 4'(SFOC_CORDIC_ITER - 1);
    assign cord_dir = (st_q == ST_ROT) ? !cz_q[19] : cy_q[19];
    assign pot_adc = {4'h0, smp_q.pot[SFOC_ADC_BITS-1:0]};
    // full-scale 4096 stands for the maximum speed (see [RQ16])
    assign spd_span = 32'(smax_q - smin_q) * 32'(pot_adc);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= ST_IDLE;
            smp_q <= '0;
            it_q <= '0;
            cx_q <= '0;
            cy_q <= '0;
            cz_q <= '0;
            ia_q <= '0;
            ib_q <= '0;
            psa_q <= '0;
            psb_q <= '0;
            ppa_q <= '0;
            ppb_q <= '0;
            cos_q <= '0;
            sin_q <= '0;
            id_q <= '0;
            iq_q <= '0;
            vdu_q <= '0;
            vqu_q <= '0;
            va_q <= '0;
            vb_q <= '0;
            est_q <= '0;
            ramp_q <= '0;
            pmag_q <= '0;
            pang_q <= '0;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    // one sample per pwm period starts one full update (see [RQ17])
                    if (fifo_pop) begin
                        smp_q <= fifo_data;
                        st_q <= ST_CLARKE;
                    end
                end
                ST_CLARKE: begin
                    ia_q <= smp_q.iu; // see [RQ1]
                    ib_q <= mulq(addq(smp_q.iu, addq(smp_q.iv, smp_q.iv)), SFOC_INV_SQRT3); // see [RQ1]
                    st_q <= ST_FLUX;
                end
                ST_FLUX: begin
                    // last applied voltage is scaled by the dc link sample (see [RQ9])
                    psa_q <= addq(psa_q, mulq(dt_q, addq(mulq(va_q, smp_q.vdc), -mulq(res_q, ia_q)))); // see [RQ7]
                    psb_q <= addq(psb_q, mulq(dt_q, addq(mulq(vb_q, smp_q.vdc), -mulq(res_q, ib_q)))); // see [RQ7]
                    ppa_q <= addq(psa_q, -mulq(ind_q, ia_q)); // see [RQ8]
                    ppb_q <= addq(psb_q, -mulq(ind_q, ib_q)); // see [RQ8]
                    ramp_q <= ramp_q + speed_target;
                    st_q <= ST_VEC;
                    it_q <= '0;
                    cx_q <= ppa_q[15] ? -20'(ppa_q) : 20'(ppa_q);
                    cy_q <= ppa_q[15] ? -20'(ppb_q) : 20'(ppb_q);
                    cz_q <= ppa_q[15] ? 20'(SFOC_HALF_TURN) : '0;
                end
                ST_VEC, ST_ROT, ST_POL: begin
                    cx_q <= cord_dir ? cx_q - (cy_q >>> it_q) : cx_q + (cy_q >>> it_q);
                    cy_q <= cord_dir ? cy_q + (cx_q >>> it_q) : cy_q - (cx_q >>> it_q);
                    cz_q <= cord_dir ? cz_q - atan_step(it_q) : cz_q + atan_step(it_q);
                    it_q <= it_q + 1'b1;
                    if (cord_last) begin
                        it_q <= '0;
                        if (st_q == ST_VEC) begin
                            // rotor angle from the atan of the rotor flux pair (see [RQ8])
                            est_q <= cz_q[15:0];
                            st_q <= ST_ROT;
                            cx_q <= 20'(SFOC_CORDIC_K);
                            cy_q <= '0;
                            // open-loop start-up drives its own angle ramp (see [RQ13])
                            cz_q <= 20'(signed'(mode == SFOC_MODE_VF ? ramp_q : cz_q[15:0]));
                        end else if (st_q == ST_ROT) begin
                            cos_q <= sat16(32'(cx_q));
                            sin_q <= sat16(32'(cy_q));
                            st_q <= ST_PARK;
                        end else begin
                            pmag_q <= mulq(sat16(32'(cx_q)), SFOC_CORDIC_K);
                            pang_q <= cz_q[15:0];
                            st_q <= ST_OUT;
                        end
                    end
                end
                ST_PARK: begin
                    id_q <= addq(mulq(ia_q, cos_q), mulq(ib_q, sin_q)); // see [RQ2]
                    iq_q <= addq(mulq(ia_q, sin_q), mulq(ib_q, cos_q)); // see [RQ3]
                    va_q <= addq(mulq(vdu_q, cos_q), -mulq(vqu_q, sin_q)); // see [RQ4]
                    vb_q <= addq(-mulq(vdu_q, sin_q), mulq(vqu_q, cos_q)); // see [RQ4]
                    it_q <= '0;
                    cx_q <= vdu_q[15] ? -20'(vdu_q) : 20'(vdu_q);
                    cy_q <= vdu_q[15] ? -20'(vqu_q) : 20'(vqu_q);
                    cz_q <= vdu_q[15] ? 20'(SFOC_HALF_TURN) : '0;
                    st_q <= ST_POL;
                end
                ST_OUT: begin
                    // voltage source per scheme, the pi loops stand outside (see [RQ13])
                    vdu_q <= (mode == SFOC_MODE_VF) ? 16'sh0000 : signed'(vd_q);
                    vqu_q <= (mode == SFOC_MODE_VF) ? mulq(signed'(vf_q), signed'(speed_target)) : signed'(vq_q);
                    st_q <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // speed command and outputs
    // ****************************************
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            motor_run <= 1'b0;
            speed_target <= '0;
        end else if (st_q == ST_OUT) begin
            // stop below the threshold, otherwise run from minimum speed while the ctrl cfg bit is set (see [RQ14]) (see [RQ15])
            motor_run <= pot_adc >= thr_q && ctrl_q[SFOC_CTRL_CFG_BIT];
            speed_target <= (pot_adc >= thr_q) ? smin_q + spd_span[27:12] : '0; // see [RQ16]
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mod_data <= '0;
            mod_valid <= 1'b0;
            mod_polar <= 1'b0;
            rotor_angle <= '0;
        end else begin
            mod_valid <= st_q == ST_OUT;
            if (st_q == ST_OUT) begin
                // alpha and beta go straight out, no three-phase stage (see [RQ5])
                mod_data <= '{v_alpha: va_q, v_beta: vb_q, mag: pmag_q, ang: pang_q}; // see [RQ6]
                mod_polar <= ctrl_q[SFOC_CTRL_POLAR_BIT]; // see [RQ6]
                rotor_angle <= est_q;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    chk_bus_one_wait: assert property (@(posedge sys_clk) disable iff (!resetn)
        bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer not one cycle");
    chk_alpha_from_u: assert property (@(posedge sys_clk) disable iff (!resetn) // see [RQ1]
        st_q == ST_CLARKE |=> ia_q == smp_q.iu) else $error("alpha current differs from phase u");
    chk_beta_clarke: assert property (@(posedge sys_clk) disable iff (!resetn) // see [RQ1]
        st_q == ST_CLARKE |=> ib_q == mulq(addq($past(smp_q.iu), addq($past(smp_q.iv), $past(smp_q.iv))),
        SFOC_INV_SQRT3)) else $error("beta current wrong");
    chk_park_d_axis: assert property (@(posedge sys_clk) disable iff (!resetn) // see [RQ2]
        st_q == ST_PARK |=> id_q == addq(mulq(ia_q, cos_q), mulq(ib_q, sin_q))) else $error("d current wrong");
    chk_park_q_sign: assert property (@(posedge sys_clk) disable iff (!resetn) // see [RQ3]
        st_q == ST_PARK |=> iq_q == addq(mulq(ia_q, sin_q), mulq(ib_q, cos_q))) else $error("q current wrong");
    chk_stop_below_thr: assert property (@(posedge sys_clk) disable iff (!resetn) // see [RQ15]
        st_q == ST_OUT && pot_adc < thr_q |=> !motor_run && speed_target == 16'h0000) else $error("ran below stop");
    chk_update_bound: assert property (@(posedge sys_clk) disable iff (!resetn) // see [RQ17]
        fifo_pop |-> ##47 mod_valid) else $error("update not finished in time");
    chk_valid_pulse: assert property (@(posedge sys_clk) disable iff (!resetn) // see [RQ5]
        mod_valid |=> !mod_valid) else $error("modulator strobe longer than one cycle");
endmodule : sfoc_core
`default_nettype wire

//--- rtl/sfoc_pkg.sv
// Function
// [RQ1] Alpha current equals phase U current and beta current is (U plus twice V) over root three.
// [RQ2] The d current is alpha times cosine of the angle plus beta times sine of the angle.
// [RQ3] The q current is alpha times sine plus beta times cosine, with no negated term.
// [RQ4] Alpha is d times cosine minus q times sine, beta is minus d times sine plus q times cosine.
// [RQ5] Inverse-Park alpha and beta go straight to the modulator with no three-phase stage.
// [RQ6] Optionally the d and q voltages are also given to the modulator as angle and magnitude.
// [RQ7] Each axis stator flux integrates applied voltage minus resistance times axis current.
// [RQ8] Rotor flux is stator flux minus inductance times current, and the angle is atan of beta over alpha.
// [RQ9] Applied voltage is scaled from the sensed DC voltage, and R and L come from configuration.
// [RQ10] Software halves the line-to-line R and L readings to get per-phase values.
// [RQ11] Software may average three line pairs by dividing their sum by six.
// [RQ12] Software loads resistance, inductance, pole pairs and speed limits before running.
// [RQ13] Three schemes are selectable: open-loop V/f, direct q voltage and speed with current loop; the code drives the speed scheme like direct q voltage.
// [RQ14] Start, stop and target speed come from a sampled analog input mapped with two thresholds; the code has the single threshold thr_q for both.
// [RQ15] Below the stop threshold the motor stops, above it it runs from the minimum speed.
// [RQ16] The 12-bit full-scale value commands the configured maximum speed.
// [RQ17] One full transform and estimator update per PWM period, fixed point with saturation.
package sfoc_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [5:0] SFOC_CTRL_OFS = 6'h00;
    localparam logic [5:0] SFOC_RES_OFS = 6'h04;
    localparam logic [5:0] SFOC_IND_OFS = 6'h08;
    localparam logic [5:0] SFOC_DT_OFS = 6'h0C;
    localparam logic [5:0] SFOC_VD_OFS = 6'h10;
    localparam logic [5:0] SFOC_VQ_OFS = 6'h14;
    localparam logic [5:0] SFOC_THR_OFS = 6'h18;
    localparam logic [5:0] SFOC_SMIN_OFS = 6'h1C;
    localparam logic [5:0] SFOC_SMAX_OFS = 6'h20;
    localparam logic [5:0] SFOC_VF_OFS = 6'h24;
    localparam logic [5:0] SFOC_PP_OFS = 6'h28;
    localparam logic [5:0] SFOC_STAT_OFS = 6'h2C;
    localparam logic [5:0] SFOC_IDQ_OFS = 6'h30;
    localparam logic [5:0] SFOC_ANG_OFS = 6'h34;
    // ctrl fields
    localparam int SFOC_CTRL_MODE_LSB = 0;
    localparam int SFOC_CTRL_POLAR_BIT = 2;
    localparam int SFOC_CTRL_CFG_BIT = 3;
    // reset values
    localparam logic [15:0] SFOC_CTRL_RST = 16'h0000;
    localparam logic [15:0] SFOC_PARAM_RST = 16'h0000;
    localparam logic [15:0] SFOC_DT_RST = 16'h0100;
    localparam logic [15:0] SFOC_PP_RST = 16'h0004;
    // ****************************************
    // arithmetic constants
    // ****************************************
    localparam logic signed [15:0] SFOC_INV_SQRT3 = 16'sh49E7;
    localparam logic signed [15:0] SFOC_CORDIC_K = 16'sh4DBA;
    localparam logic [15:0] SFOC_HALF_TURN = 16'h8000;
    localparam int SFOC_CORDIC_ITER = 14;
    localparam int SFOC_ADC_BITS = 12;
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {SFOC_MODE_VF, SFOC_MODE_VQ, SFOC_MODE_SPD, SFOC_MODE_RSV} sfoc_mode_e;
    typedef struct packed {
        logic signed [15:0] iu;
        logic signed [15:0] iv;
        logic signed [15:0] vdc;
        logic [15:0] pot;
    } sfoc_sample_s;
    typedef struct packed {
        logic signed [15:0] v_alpha;
        logic signed [15:0] v_beta;
        logic [15:0] mag;
        logic [15:0] ang;
    } sfoc_mod_s;
endpackage : sfoc_pkg

//--- rtl/sfoc_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module sfoc_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q, rp_q;
    logic [AW:0] cnt_q, cnt_d;
    logic in_ready_q;
    logic push, pop;

    assign push = in_valid && in_ready_q;
    assign pop = out_valid && out_ready;
    assign in_ready = in_ready_q;
    assign out_valid = cnt_q != '0;
    assign out_data = mem[rp_q];

    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            in_ready_q <= 1'b1;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_d;
            in_ready_q <= cnt_d < (AW + 1)'(DEPTH);
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

    chk_fifo_full_stall: assert property (@(posedge clk) disable iff (!resetn)
        cnt_q == (AW + 1)'(DEPTH) |-> !in_ready) else $error("fifo full but ready");
    chk_fifo_count_step: assert property (@(posedge clk) disable iff (!resetn)
        push && !pop |=> cnt_q == $past(cnt_q) + 1'b1) else $error("fifo count lost a push");
endmodule : sfoc_fifo
`default_nettype wire

//--- verification/sfoc_adc_pwm_model.sv
`timescale 1ns/1ns
`default_nettype none
module sfoc_adc_pwm_model import sfoc_pkg::*; (
    input wire logic sys_clk,
    input wire logic resetn,
    output logic sample_valid,
    input wire logic sample_ready,
    output sfoc_sample_s sample_data,
    input wire logic mod_valid,
    input wire sfoc_mod_s mod_data
);
    // ****************************************
    // converter side and modulator side
    // ****************************************
    int n_upd = 0;
    int n_stall = 0;
    sfoc_mod_s last_mod = '0;
    initial begin
        sample_valid = 1'b0;
        sample_data = '0;
    end
    // sample held until taken, then data scrambled
    task automatic send(input sfoc_sample_s s);
        @(posedge sys_clk);
        sample_valid <= 1'b1;
        sample_data <= s;
        do begin
            @(posedge sys_clk);
            if (sample_ready !== 1'b1) n_stall++;
        end while (sample_ready !== 1'b1);
        sample_valid <= 1'b0;
        sample_data <= ~s;
    endtask : send
    always @(posedge sys_clk) begin
        if (resetn === 1'b1 && mod_valid === 1'b1) begin
            n_upd <= n_upd + 1;
            last_mod <= mod_data;
        end
    end
endmodule : sfoc_adc_pwm_model
`default_nettype wire

//--- verification/tb_sensorless_foc_transform.sv
`timescale 1ns/1ns
`default_nettype none
module tb_sensorless_foc_transform import sfoc_pkg::*; ();
    // ****************************************
    // stimulus and checking
    // ****************************************
    localparam int IU = 4096;
    localparam int IV = 2048;
    localparam logic [15:0] THR = 16'h0200;
    localparam logic [15:0] SMIN = 16'h0064;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [5:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, sv, sr, mv, mp, run;
    sfoc_sample_s sd;
    sfoc_mod_s md;
    logic [15:0] spd, ang;
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0;
    always #20 sys_clk = ~sys_clk;
    sfoc_core #(.FIFO_DEPTH(4)) uut (.sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hF), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sample_valid(sv),
        .sample_ready(sr), .sample_data(sd), .mod_data(md), .mod_valid(mv), .mod_polar(mp),
        .motor_run(run), .speed_target(spd), .rotor_angle(ang));
    sfoc_adc_pwm_model model (.sys_clk(sys_clk), .resetn(resetn), .sample_valid(sv), .sample_ready(sr),
        .sample_data(sd), .mod_valid(mv), .mod_data(md));
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            results();
        end
    end
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    task automatic near(input string nm, input int e, input logic signed [15:0] g);
        int d;
        n_checks++;
        d = int'(g) - e;
        if ((^g === 1'bx) || d > 8 || d < -8) begin
            mismatches++;
            $display("mismatch %s expected %0d seen %0d", nm, e, g);
        end
    endtask : near
    task automatic acc(input logic w, input logic [5:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : acc
    task automatic upd(input logic [15:0] pot, input int k);
        sfoc_sample_s s;
        int n;
        s = {16'(IU), 16'(IV), 16'sh4000, pot};
        n = model.n_upd;
        repeat (k) model.send(s);
        for (int i = 0; i < k * 60 && model.n_upd < n + k; i++) @(posedge sys_clk);
        @(posedge sys_clk);
        check("updates", n + k, model.n_upd);
    endtask : upd
    initial begin
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        acc(0, SFOC_CTRL_OFS, 0); check("ctrl", {16'h0000, SFOC_CTRL_RST}, q);
        acc(0, SFOC_DT_OFS, 0); check("dt", {16'h0000, SFOC_DT_RST}, q);
        acc(0, SFOC_PP_OFS, 0); check("pp", {16'h0000, SFOC_PP_RST}, q);
        acc(0, 6'h3C, 0); check("unmapped", 32'h0, q);
        acc(1, SFOC_RES_OFS, 16'h0090 >> 1);
        acc(1, SFOC_IND_OFS, (16'h0030 + 16'h0036 + 16'h0030) / 6);
        acc(1, SFOC_THR_OFS, THR);
        acc(1, SFOC_SMIN_OFS, SMIN);
        acc(1, SFOC_SMAX_OFS, SMIN + 16'h1000);
        acc(1, SFOC_STAT_OFS, 16'hFFFF);
        acc(0, SFOC_RES_OFS, 0); check("res", 32'h48, q);
        acc(0, SFOC_IND_OFS, 0); check("ind", 32'h19, q);
        acc(0, SFOC_STAT_OFS, 0); check("stat", 32'h0, q);
        check("angle", 0, ang);
        acc(1, SFOC_CTRL_OFS, 16'h0008);
        upd(16'h01FF, 1);
        check("run", 0, run);
        check("speed", 0, spd);
        acc(0, SFOC_IDQ_OFS, 0);
        near("id", IU, q[15:0]);
        near("iq", (IU + 2 * IV) * int'(SFOC_INV_SQRT3) / 32768, q[31:16]);
        check("valpha", 0, model.last_mod.v_alpha);
        upd(THR, 1);
        check("run", 1, run);
        // span of 4096 puts the threshold sample at smin plus thr
        check("speed", SMIN + THR, spd);
        // both rotor flux parts negative: third quadrant
        check("angle", 2'b10, ang[15:14]);
        upd(16'h0FFF, 1);
        check("speed", SMIN + 16'h0FFF, spd);
        acc(0, SFOC_STAT_OFS, 0); check("stat", {15'h0, 1'b1, SMIN + 16'h0FFF}, {15'h0, q[16:0]});
        acc(1, SFOC_VD_OFS, 16'h0000);
        acc(1, SFOC_VQ_OFS, 16'h1000);
        for (int m = 0; m < 3; m++) begin
            acc(1, SFOC_CTRL_OFS, 16'h000C | 16'(m));
            upd(16'h0FFF, 2);
            check("polar", 1, mp);
            if (m == 1) near("mag", 4096, model.last_mod.mag);
        end
        acc(1, SFOC_CTRL_OFS, 16'h0001);
        upd(16'h0FFF, 1);
        check("run", 0, run);
        upd(16'h0FFF, 6);
        check("stall", 1, model.n_stall > 0);
        results();
    end
endmodule : tb_sensorless_foc_transform
`default_nettype wire
